/* File: hw/csfl_core.sv */
// status flag register with flag update, jump condition and operand range unit
//
// Contract
// [RQ1] eight-bit register, upper four feed jumps
// [RQ2] plain loads write the status register
// [RQ3] software avoids flag ops targeting the register
// [RQ4] AND updates zero, sign and overflow
// [RQ5] overflow set on signed range excursion
// [RQ6] logic operations clear overflow
// [RQ7] sign copies result msb
// [RQ8] zero set when result is zero
// [RQ9] carry on carry-out or borrow at bit7
// [RQ10] rotate/shift carry holds last bit out
// [RQ11] carry can be set, cleared, inverted
// [RQ12] registers 0-255, working registers 0-15
// [RQ13] pairs even 0-254, working pairs 0-14
// [RQ14] relative offset signed, added to next address
// [RQ15] long addresses 0-8191, short offset signed
// [RQ16] jumps use only carry, zero, sign, overflow
// [RQ17] four-bit selector picks the jump condition
// [RQ18] low four bits are plain storage
`timescale 1ns/100ps
module csfl_core (
    input wire logic clk_in, // core clock, 50 MHz
    input wire logic rst_in, // synchronous, active high
    input wire logic op_valid_in, // one operation this cycle
    input wire csfl_pkg::csfl_op_t op_in, // operation code
    input wire logic [7:0] op_a_in, // destination operand
    input wire logic [7:0] op_b_in, // source operand
    input wire logic reg_wr_in, // register file write strobe
    input wire logic [7:0] reg_addr_in, // register file address
    input wire logic [7:0] reg_wdata_in, // register file write data
    input wire logic jump_eval_in, // evaluate a conditional jump
    input wire logic [3:0] jump_condition_selector_in, // condition selector
    input wire logic addr_req_in, // check and form an operand address
    input wire csfl_pkg::csfl_amode_t addr_mode_in, // addressing form
    input wire logic [12:0] addr_operand_in, // register, offset or address field
    input wire logic [15:0] addr_base_in, // next pc or pair contents
    output logic [7:0] flags_out, // status register contents
    output logic [7:0] result_out, // operation result
    output logic result_valid_out, // result pulse
    output logic result_wr_out, // result to be written back
    output logic jump_take_out, // jump condition held
    output logic jump_valid_out, // jump answer pulse
    output logic [15:0] ea_out, // formed address
    output logic ea_ok_out, // operand within its range
    output logic ea_valid_out // address answer pulse
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] flags_r; // status register
    logic [7:0] result_r; // registered result
    logic result_valid_r; // result pulse
    logic result_wr_r; // writeback flag
    logic jump_take_r; // registered condition
    logic jump_valid_r; // jump pulse
    logic [15:0] ea_r; // registered address
    logic ea_ok_r; // registered range check
    logic ea_valid_r; // address pulse
    logic flags_hit; // register write targets the status register

    csfl_op_if op_if (); // link to the helpers

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // sign extend an 8-bit offset to 16 bits
    function automatic logic [15:0] csfl_sext8(input logic [7:0] off);
        csfl_sext8 = {{8{off[7]}}, off};
    endfunction

    // range check and address forming for one addressing form
    function automatic logic [16:0] csfl_ea(input csfl_pkg::csfl_amode_t mode,
                                            input logic [12:0] opnd,
                                            input logic [15:0] base);
        logic ok;
        logic [15:0] ea;
        ok = 1'b1;
        ea = {3'h0, opnd};
        case (mode)
            csfl_pkg::CSFL_AM_WREG: ok = (opnd <= csfl_pkg::CSFL_WREG_MAX); // RQ12
            csfl_pkg::CSFL_AM_REG: ok = (opnd <= csfl_pkg::CSFL_REG_MAX); // RQ12
            csfl_pkg::CSFL_AM_PAIR: ok = !opnd[0] && (opnd <= csfl_pkg::CSFL_PAIR_MAX); // RQ13
            csfl_pkg::CSFL_AM_WPAIR: ok = !opnd[0] && (opnd <= csfl_pkg::CSFL_WPAIR_MAX); // RQ13
            // relative and short index take an 8-bit signed offset
            csfl_pkg::CSFL_AM_REL, csfl_pkg::CSFL_AM_XS: begin
                ok = (opnd[12:8] == 5'h00); // RQ14 RQ15
                ea = base + csfl_sext8(opnd[7:0]); // RQ14 RQ15
            end
            // long index adds the 13-bit field to the pair
            csfl_pkg::CSFL_AM_XL: begin
                ok = (opnd <= csfl_pkg::CSFL_LONG_MAX); // RQ15
                ea = base + {3'h0, opnd}; // RQ15
            end
            default: ok = (opnd <= csfl_pkg::CSFL_LONG_MAX); // direct, RQ15
        endcase
        csfl_ea = {ok, ea};
    endfunction

    // ----------------------------------------
    // helper instances
    // ----------------------------------------
    assign op_if.op = op_valid_in ? op_in : csfl_pkg::CSFL_OP_NONE;
    assign op_if.a = op_a_in;
    assign op_if.b = op_b_in;
    assign op_if.flags = flags_r;
    assign op_if.sel = jump_condition_selector_in;

    csfl_alu u_alu (
        .op_if(op_if.alu)
    );

    csfl_cond u_cond (
        .op_if(op_if.cond)
    );

    assign flags_hit = reg_wr_in && (reg_addr_in == csfl_pkg::CSFL_FLAGS_OFFSET);

    // ----------------------------------------
    // status register
    // ----------------------------------------
    // operation update wins over a same-cycle load; that case is undefined
    // for software anyway, so the cheaper priority was taken
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_r <= csfl_pkg::CSFL_FLAGS_RESET;
        end else if (op_valid_in) begin
            flags_r <= op_if.flags_nxt; // RQ3 RQ4 RQ18
        end else if (flags_hit) begin
            flags_r <= reg_wdata_in; // RQ2 RQ18
        end
    end

    // ----------------------------------------
    // result path
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            result_r <= 8'h00;
            result_valid_r <= 1'b0;
            result_wr_r <= 1'b0;
        end else begin
            result_valid_r <= op_valid_in;
            result_wr_r <= op_valid_in && op_if.result_wr;
            if (op_valid_in) begin
                result_r <= op_if.result;
            end
        end
    end

    // ----------------------------------------
    // jump condition; reads flags before any same-cycle update
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            jump_take_r <= 1'b0;
            jump_valid_r <= 1'b0;
        end else begin
            jump_valid_r <= jump_eval_in;
            if (jump_eval_in) begin
                jump_take_r <= op_if.take; // RQ1 RQ16
            end
        end
    end

    // ----------------------------------------
    // operand address unit
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ea_r <= 16'h0000;
            ea_ok_r <= 1'b0;
            ea_valid_r <= 1'b0;
        end else begin
            ea_valid_r <= addr_req_in;
            if (addr_req_in) begin
                {ea_ok_r, ea_r} <= csfl_ea(addr_mode_in, addr_operand_in, addr_base_in);
            end
        end
    end

    assign flags_out = flags_r;
    assign result_out = result_r;
    assign result_valid_out = result_valid_r;
    assign result_wr_out = result_wr_r;
    assign jump_take_out = jump_take_r;
    assign jump_valid_out = jump_valid_r;
    assign ea_out = ea_r;
    assign ea_ok_out = ea_ok_r;
    assign ea_valid_out = ea_valid_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // logic family clears overflow
    sequence s_logic_op;
        op_valid_in && (op_in inside {csfl_pkg::CSFL_OP_AND, csfl_pkg::CSFL_OP_OR,
                                      csfl_pkg::CSFL_OP_XOR, csfl_pkg::CSFL_OP_COM});
    endsequence

    property p_logic_v;
        s_logic_op |=> !flags_r[csfl_pkg::CSFL_BIT_V] && result_valid_out;
    endproperty
    a_logic_v: assert property (p_logic_v) else $error("overflow not cleared"); // RQ6

    property p_zero_sign;
        op_valid_in && (op_in inside {[csfl_pkg::CSFL_OP_ADD:csfl_pkg::CSFL_OP_SRA]})
            |=> flags_r[csfl_pkg::CSFL_BIT_Z] == (result_out == 8'h00)
                && flags_r[csfl_pkg::CSFL_BIT_S] == result_out[7];
    endproperty
    a_zero_sign: assert property (p_zero_sign) else $error("zero or sign wrong"); // RQ7 RQ8

    // nine-bit sum keeps the carry
    property p_add_carry;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_ADD
            |=> flags_r[csfl_pkg::CSFL_BIT_C]
                == (({1'b0, $past(op_a_in)} + {1'b0, $past(op_b_in)}) > 9'h0ff);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong"); // RQ9

    property p_add_ovf;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_ADD
            |=> flags_r[csfl_pkg::CSFL_BIT_V]
                == (($signed({$past(op_a_in[7]), $past(op_a_in)})
                     + $signed({$past(op_b_in[7]), $past(op_b_in)})) > 9'sd127
                    || ($signed({$past(op_a_in[7]), $past(op_a_in)})
                     + $signed({$past(op_b_in[7]), $past(op_b_in)})) < -9'sd128);
    endproperty
    a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong"); // RQ5

    // carry control only
    property p_scf;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_SCF
            |=> flags_r[csfl_pkg::CSFL_BIT_C] && flags_r[6:0] == $past(flags_r[6:0]);
    endproperty
    a_scf: assert property (p_scf) else $error("set carry disturbed flags"); // RQ11

    property p_ccf;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_CCF
            |=> flags_r[csfl_pkg::CSFL_BIT_C] != $past(flags_r[csfl_pkg::CSFL_BIT_C]);
    endproperty
    a_ccf: assert property (p_ccf) else $error("carry not inverted"); // RQ11

    property p_rl_carry;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_RL
            |=> flags_r[csfl_pkg::CSFL_BIT_C] == $past(op_a_in[7]);
    endproperty
    a_rl_carry: assert property (p_rl_carry) else $error("rotate carry wrong"); // RQ10

    // lone load lands next edge
    property p_load;
        flags_hit && !op_valid_in |=> flags_r == $past(reg_wdata_in);
    endproperty
    a_load: assert property (p_load) else $error("status load lost"); // RQ2

    property p_low_nibble;
        op_valid_in |=> flags_r[3:0] == $past(flags_r[3:0]);
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("low bits changed"); // RQ18

    // odd pairs refused
    property p_pair_odd;
        addr_req_in && addr_mode_in == csfl_pkg::CSFL_AM_PAIR && addr_operand_in[0]
            |=> ea_valid_out && !ea_ok_out;
    endproperty
    a_pair_odd: assert property (p_pair_odd) else $error("odd pair accepted"); // RQ13

    // selector 8 always true
    property p_jump_always;
        jump_eval_in && jump_condition_selector_in == 4'h8 |=> jump_valid_out && jump_take_out;
    endproperty
    a_jump_always: assert property (p_jump_always) else $error("always-true failed"); // RQ17

    property p_jump_zero;
        jump_eval_in && jump_condition_selector_in == 4'h6
            |=> jump_take_out == $past(flags_r[csfl_pkg::CSFL_BIT_Z]);
    endproperty
    a_jump_zero: assert property (p_jump_zero) else $error("zero jump wrong"); // RQ16

    property p_result_pulse;
        op_valid_in |=> result_valid_out;
    endproperty
    a_result_pulse: assert property (p_result_pulse) else $error("no result pulse");

    property p_result_idle;
        !op_valid_in |=> !result_valid_out && !result_wr_out;
    endproperty
    a_result_idle: assert property (p_result_idle) else $error("stray result pulse");

    property p_jump_pulse;
        jump_eval_in |=> jump_valid_out;
    endproperty
    a_jump_pulse: assert property (p_jump_pulse) else $error("no jump pulse");

    property p_sub_borrow;
        op_valid_in && op_in == csfl_pkg::CSFL_OP_SUB
            |=> flags_r[csfl_pkg::CSFL_BIT_C] == ($past(op_a_in) < $past(op_b_in));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong"); // RQ9
endmodule

/* File: hw/csfl_pkg.sv */
// package: constants, opcodes and addressing modes of the status flag block
package csfl_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CSFL_FLAGS_OFFSET = 8'hd5; // status register address
    localparam logic [7:0] CSFL_FLAGS_RESET = 8'h00; // value after reset
    // ----------------------------------------
    // field positions inside the status register
    // ----------------------------------------
    localparam int CSFL_BIT_V = 4; // overflow
    localparam int CSFL_BIT_S = 5; // sign
    localparam int CSFL_BIT_Z = 6; // zero
    localparam int CSFL_BIT_C = 7; // carry
    // ----------------------------------------
    // operand ranges
    // ----------------------------------------
    localparam logic [12:0] CSFL_LONG_MAX = 13'h1fff; // 8191, long index and direct
    localparam logic [12:0] CSFL_PAIR_MAX = 13'h00fe; // 254, register pair
    localparam logic [12:0] CSFL_WPAIR_MAX = 13'h000e; // 14, working pair
    localparam logic [12:0] CSFL_WREG_MAX = 13'h000f; // 15, working register
    localparam logic [12:0] CSFL_REG_MAX = 13'h00ff; // 255, general register
    // ----------------------------------------
    // operations that reach the flag logic
    // ----------------------------------------
    typedef enum logic [4:0] {
        CSFL_OP_NONE = 5'h00,
        CSFL_OP_ADD = 5'h01,
        CSFL_OP_ADC = 5'h02,
        CSFL_OP_SUB = 5'h03,
        CSFL_OP_SBC = 5'h04,
        CSFL_OP_CP = 5'h05,
        CSFL_OP_INC = 5'h06,
        CSFL_OP_DEC = 5'h07,
        CSFL_OP_AND = 5'h08,
        CSFL_OP_OR = 5'h09,
        CSFL_OP_XOR = 5'h0a,
        CSFL_OP_COM = 5'h0b,
        CSFL_OP_TCM = 5'h0c,
        CSFL_OP_TM = 5'h0d,
        CSFL_OP_RL = 5'h0e,
        CSFL_OP_RLC = 5'h0f,
        CSFL_OP_RR = 5'h10,
        CSFL_OP_RRC = 5'h11,
        CSFL_OP_SRA = 5'h12,
        CSFL_OP_SCF = 5'h13,
        CSFL_OP_RCF = 5'h14,
        CSFL_OP_CCF = 5'h15
    } csfl_op_t;
    // ----------------------------------------
    // addressing forms checked by the operand unit
    // ----------------------------------------
    typedef enum logic [2:0] {
        CSFL_AM_WREG = 3'h0,
        CSFL_AM_REG = 3'h1,
        CSFL_AM_PAIR = 3'h2,
        CSFL_AM_WPAIR = 3'h3,
        CSFL_AM_REL = 3'h4,
        CSFL_AM_XS = 3'h5,
        CSFL_AM_XL = 3'h6,
        CSFL_AM_DA = 3'h7
    } csfl_amode_t;
endpackage

/* File: hw/csfl_op_if.sv */
// interface: operation and condition signals between the core and its helpers
`timescale 1ns/100ps
interface csfl_op_if;
    csfl_pkg::csfl_op_t op; // operation in flight
    logic [7:0] a; // destination operand
    logic [7:0] b; // source operand
    logic [7:0] flags; // current status register
    logic [7:0] result; // operation result
    logic [7:0] flags_nxt; // status register after the operation
    logic result_wr; // result goes back to the destination
    logic [3:0] sel; // jump condition selector
    logic take; // condition holds
    modport core (output op, a, b, flags, sel, input result, flags_nxt, result_wr, take);
    modport alu (input op, a, b, flags, output result, flags_nxt, result_wr);
    modport cond (input flags, sel, output take);
endinterface

/* File: hw/csfl_alu.sv */
// flag computation for arithmetic, logic, bit-test, rotate and shift operations
`timescale 1ns/100ps
module csfl_alu (
    csfl_op_if.alu op_if
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // 9-bit add, bit 8 is the carry out of bit 7
    function automatic logic [8:0] csfl_add9(input logic [7:0] x, input logic [7:0] y,
                                             input logic ci);
        csfl_add9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    endfunction

    logic [8:0] sum; // wide sum for carry
    logic [7:0] res; // result byte
    logic c; // new carry
    logic v; // new overflow
    logic zs; // zero and sign follow the result
    logic wr; // result written back

    // ----------------------------------------
    // operation decode
    // ----------------------------------------
    always_comb begin
        sum = 9'h000;
        res = op_if.a;
        c = op_if.flags[csfl_pkg::CSFL_BIT_C];
        v = op_if.flags[csfl_pkg::CSFL_BIT_V];
        zs = 1'b1;
        wr = 1'b1;
        case (op_if.op)
            // additions: carry out of bit 7
            csfl_pkg::CSFL_OP_ADD, csfl_pkg::CSFL_OP_ADC: begin
                sum = csfl_add9(op_if.a, op_if.b,
                                op_if.op == csfl_pkg::CSFL_OP_ADC ? c : 1'b0);
                res = sum[7:0];
                c = sum[8]; // RQ9
                v = (op_if.a[7] == op_if.b[7]) && (res[7] != op_if.a[7]); // RQ5
            end
            // subtractions: carry means a borrow out of bit 7
            csfl_pkg::CSFL_OP_SUB, csfl_pkg::CSFL_OP_SBC, csfl_pkg::CSFL_OP_CP: begin
                sum = csfl_add9(op_if.a, ~op_if.b,
                                op_if.op == csfl_pkg::CSFL_OP_SBC ? ~c : 1'b1);
                res = sum[7:0];
                c = ~sum[8]; // RQ9
                v = (op_if.a[7] != op_if.b[7]) && (res[7] != op_if.a[7]); // RQ5
                wr = (op_if.op != csfl_pkg::CSFL_OP_CP); // compare keeps the operand
            end
            // increment and decrement leave carry alone
            csfl_pkg::CSFL_OP_INC: begin
                res = op_if.a + 8'h01;
                v = ~op_if.a[7] & res[7]; // RQ5
            end
            csfl_pkg::CSFL_OP_DEC: begin
                res = op_if.a - 8'h01;
                v = op_if.a[7] & ~res[7]; // RQ5
            end
            // logic family: overflow always cleared
            csfl_pkg::CSFL_OP_AND: begin
                res = op_if.a & op_if.b;
                v = 1'b0; // RQ4 RQ6
            end
            csfl_pkg::CSFL_OP_OR: begin
                res = op_if.a | op_if.b;
                v = 1'b0; // RQ6
            end
            csfl_pkg::CSFL_OP_XOR: begin
                res = op_if.a ^ op_if.b;
                v = 1'b0; // RQ6
            end
            csfl_pkg::CSFL_OP_COM: begin
                res = ~op_if.a;
                v = 1'b0; // RQ6
            end
            // bit tests: flags only, operand untouched
            csfl_pkg::CSFL_OP_TM: begin
                res = op_if.a & op_if.b;
                v = 1'b0; // RQ6
                wr = 1'b0;
            end
            csfl_pkg::CSFL_OP_TCM: begin
                res = ~op_if.a & op_if.b;
                v = 1'b0; // RQ6
                wr = 1'b0;
            end
            // rotates and shift: carry takes the bit moved out
            csfl_pkg::CSFL_OP_RL: begin
                res = {op_if.a[6:0], op_if.a[7]};
                c = op_if.a[7]; // RQ10
                v = op_if.a[7] ^ res[7];
            end
            csfl_pkg::CSFL_OP_RLC: begin
                res = {op_if.a[6:0], c};
                c = op_if.a[7]; // RQ10
                v = op_if.a[7] ^ res[7];
            end
            csfl_pkg::CSFL_OP_RR: begin
                res = {op_if.a[0], op_if.a[7:1]};
                c = op_if.a[0]; // RQ10
                v = op_if.a[7] ^ res[7];
            end
            csfl_pkg::CSFL_OP_RRC: begin
                res = {c, op_if.a[7:1]};
                c = op_if.a[0]; // RQ10
                v = op_if.a[7] ^ res[7];
            end
            csfl_pkg::CSFL_OP_SRA: begin
                res = {op_if.a[7], op_if.a[7:1]};
                c = op_if.a[0]; // RQ10
                v = 1'b0; // sign never changes
            end
            // carry control: no other flag moves
            csfl_pkg::CSFL_OP_SCF: begin
                c = 1'b1; // RQ11
                zs = 1'b0;
                wr = 1'b0;
            end
            csfl_pkg::CSFL_OP_RCF: begin
                c = 1'b0; // RQ11
                zs = 1'b0;
                wr = 1'b0;
            end
            csfl_pkg::CSFL_OP_CCF: begin
                c = ~c; // RQ11
                zs = 1'b0;
                wr = 1'b0;
            end
            default: begin
                zs = 1'b0;
                wr = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // outputs back to the core
    // ----------------------------------------
    // low nibble is plain storage and passes through
    assign op_if.flags_nxt = {c, zs ? (res == 8'h00) : op_if.flags[csfl_pkg::CSFL_BIT_Z],
                              zs ? res[7] : op_if.flags[csfl_pkg::CSFL_BIT_S], v,
                              op_if.flags[3:0]}; // RQ7 RQ8 RQ18
    assign op_if.result = res;
    assign op_if.result_wr = wr;
endmodule

/* File: hw/csfl_cond.sv */
// jump condition evaluation from the upper four status bits
`timescale 1ns/100ps
module csfl_cond (
    csfl_op_if.cond op_if
);
    logic base; // condition before the selector's invert bit
    logic s_x_v; // signed less-than term

    // ----------------------------------------
    // selector decode; top bit inverts the sense
    // ----------------------------------------
    always_comb begin
        s_x_v = op_if.flags[csfl_pkg::CSFL_BIT_S] ^ op_if.flags[csfl_pkg::CSFL_BIT_V];
        case (op_if.sel[2:0]) // RQ16 RQ17
            3'h0: base = 1'b0; // never / always
            3'h1: base = s_x_v; // less than
            3'h2: base = op_if.flags[csfl_pkg::CSFL_BIT_Z] | s_x_v; // less or equal
            3'h3: base = op_if.flags[csfl_pkg::CSFL_BIT_C] | op_if.flags[csfl_pkg::CSFL_BIT_Z];
            3'h4: base = op_if.flags[csfl_pkg::CSFL_BIT_V]; // overflow
            3'h5: base = op_if.flags[csfl_pkg::CSFL_BIT_S]; // minus
            3'h6: base = op_if.flags[csfl_pkg::CSFL_BIT_Z]; // zero
            default: base = op_if.flags[csfl_pkg::CSFL_BIT_C]; // carry
        endcase
    end

    assign op_if.take = base ^ op_if.sel[3]; // RQ1
endmodule

/* File: tb/test_cpu_status_flags_logic.sv */
// self-checking bench for the status flag block
`timescale 1ns/100ps
module test_cpu_status_flags_logic;
    logic clk_in = 1'b0, rst_in = 1'b1;
    logic op_valid_in = 1'b0, reg_wr_in = 1'b0, jump_eval_in = 1'b0, addr_req_in = 1'b0;
    csfl_pkg::csfl_op_t op_in = csfl_pkg::CSFL_OP_NONE;
    csfl_pkg::csfl_amode_t addr_mode_in = csfl_pkg::CSFL_AM_WREG;
    logic [7:0] op_a_in = 8'h00, op_b_in = 8'h00, reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    logic [3:0] jump_condition_selector_in = 4'h0;
    logic [12:0] addr_operand_in = 13'h0000;
    logic [15:0] addr_base_in = 16'h0000, ea_out;
    logic [7:0] flags_out, result_out;
    logic result_valid_out, result_wr_out, jump_take_out, jump_valid_out, ea_ok_out, ea_valid_out;
    int err_total = 0, n_tests = 0;
    always #10 clk_in = ~clk_in; // 50 MHz
    csfl_core i_dut (.*);
    // counted comparison, unknowns never match
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // one operation; result only judged when it is written back
    task op(input csfl_pkg::csfl_op_t o, input logic [7:0] a, b, input logic w,
            input logic [7:0] r, f);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_in <= o;
        op_a_in <= a;
        op_b_in <= b;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        chk("result_valid", 1'b1, result_valid_out);
        chk("result_wr", w, result_wr_out);
        if (w) chk("result", r, result_out);
        chk("flags", f, flags_out);
    endtask
    // register file write, flags seen one cycle later
    task wr(input logic [7:0] ad, d, f);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
        chk("flags", f, flags_out);
    endtask
    // t holds the expected outcome of the eight base selectors
    task jmp(input logic [3:0] s, input logic [7:0] t);
        @(posedge clk_in);
        jump_eval_in <= 1'b1;
        jump_condition_selector_in <= s;
        @(posedge clk_in);
        jump_eval_in <= 1'b0;
        #1;
        chk("jump_valid", 1'b1, jump_valid_out);
        chk("jump_take", t[s[2:0]] ^ s[3], jump_take_out);
    endtask
    task ad(input csfl_pkg::csfl_amode_t m, input logic [12:0] o, input logic [15:0] b, e,
            input logic k);
        @(posedge clk_in);
        addr_req_in <= 1'b1;
        addr_mode_in <= m;
        addr_operand_in <= o;
        addr_base_in <= b;
        @(posedge clk_in);
        addr_req_in <= 1'b0;
        #1;
        chk("ea_valid", 1'b1, ea_valid_out);
        chk("ea", e, ea_out);
        chk("ea_ok", k, ea_ok_out);
    endtask
    // low nibble stays 0xf through the alu runs
    task t_regs;
        #1;
        chk("flags", 8'h00, flags_out);
        wr(8'hd4, 8'hff, 8'h00);
        wr(8'hd5, 8'h0f, 8'h0f);
    endtask
    task t_alu;
        op(csfl_pkg::CSFL_OP_ADD, 8'h7f, 8'h01, 1'b1, 8'h80, 8'h3f);
        op(csfl_pkg::CSFL_OP_ADD, 8'hff, 8'h01, 1'b1, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_SUB, 8'h80, 8'h01, 1'b1, 8'h7f, 8'h1f);
        op(csfl_pkg::CSFL_OP_AND, 8'hf0, 8'h0f, 1'b1, 8'h00, 8'h4f);
        op(csfl_pkg::CSFL_OP_CP, 8'h03, 8'h05, 1'b0, 8'h00, 8'haf);
        op(csfl_pkg::CSFL_OP_ADC, 8'h01, 8'h01, 1'b1, 8'h03, 8'h0f);
        op(csfl_pkg::CSFL_OP_RL, 8'h81, 8'h00, 1'b1, 8'h03, 8'h9f);
        op(csfl_pkg::CSFL_OP_SRA, 8'h01, 8'h00, 1'b1, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_RCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h4f);
        op(csfl_pkg::CSFL_OP_SCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_CCF, 8'h00, 8'h00, 1'b0, 8'h00, 8'h4f);
        op(csfl_pkg::CSFL_OP_RLC, 8'h80, 8'h00, 1'b1, 8'h00, 8'hdf);
        op(csfl_pkg::CSFL_OP_SBC, 8'h10, 8'h01, 1'b1, 8'h0e, 8'h0f);
        op(csfl_pkg::CSFL_OP_RRC, 8'h01, 8'h00, 1'b1, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_RR, 8'h01, 8'h00, 1'b1, 8'h80, 8'hbf);
        op(csfl_pkg::CSFL_OP_INC, 8'hff, 8'h00, 1'b1, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_DEC, 8'h80, 8'h00, 1'b1, 8'h7f, 8'h9f);
        op(csfl_pkg::CSFL_OP_OR, 8'h80, 8'h01, 1'b1, 8'h81, 8'haf);
        op(csfl_pkg::CSFL_OP_XOR, 8'h55, 8'h55, 1'b1, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_COM, 8'h00, 8'h00, 1'b1, 8'hff, 8'haf);
        op(csfl_pkg::CSFL_OP_TM, 8'h0f, 8'hf0, 1'b0, 8'h00, 8'hcf);
        op(csfl_pkg::CSFL_OP_TCM, 8'h0f, 8'hf0, 1'b0, 8'h00, 8'haf);
    endtask
    // every selector against two flag pictures, low bits set in the second
    task t_jump;
        logic [7:0] f [2] = '{8'ha0, 8'h4f};
        logic [7:0] t [2] = '{8'hae, 8'h4c};
        for (int i = 0; i < 2; i++) begin
            wr(8'hd5, f[i], f[i]);
            for (int s = 0; s < 16; s++) begin
                jmp(4'(s), t[i]);
            end
        end
    endtask
    task t_addr;
        ad(csfl_pkg::CSFL_AM_WREG, 13'h0010, 16'h0, 16'h0010, 1'b0);
        ad(csfl_pkg::CSFL_AM_REG, 13'h00ff, 16'h0, 16'h00ff, 1'b1);
        ad(csfl_pkg::CSFL_AM_PAIR, 13'h00fd, 16'h0, 16'h00fd, 1'b0);
        ad(csfl_pkg::CSFL_AM_WPAIR, 13'h000e, 16'h0, 16'h000e, 1'b1);
        ad(csfl_pkg::CSFL_AM_REL, 13'h0080, 16'h0100, 16'h0080, 1'b1);
        ad(csfl_pkg::CSFL_AM_XL, 13'h1fff, 16'h0010, 16'h200f, 1'b1);
        ad(csfl_pkg::CSFL_AM_XS, 13'h00ff, 16'h0200, 16'h01ff, 1'b1);
        ad(csfl_pkg::CSFL_AM_DA, 13'h1fff, 16'h1234, 16'h1fff, 1'b1);
    endtask
    task report_and_stop;
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_alu();
        t_jump();
        t_addr();
        report_and_stop();
    end
    // hang guard, the run needs about 150 cycles
    initial begin
        repeat (2000) @(posedge clk_in);
        err_total++;
        report_and_stop();
    end
endmodule
